// File: hw/fircb_top.sv
// Four paged FIR coefficient banks with a shared sequential filter
module fircb_top #(
  parameter int N_CH = fircb_pkg::N_CH
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register frames on the link clock
  input wire logic link_clk,
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  output logic frame_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  // Bank selection fields
  input wire logic [15:0] bank_select_cfg_low,
  input wire logic [15:0] bank_select_cfg_high,
  // Sensor samples
  input wire logic sample_valid,
  input wire logic [2:0] sample_ch,
  input wire logic [15:0] sample_data,
  output logic sample_ready,
  // Filtered results
  output logic filt_valid,
  output logic [25:0] filt_data,
  input wire logic filt_ready
);
  localparam int NT = fircb_pkg::N_TAPS;
  localparam int NM = fircb_pkg::N_BANKS * fircb_pkg::N_TAPS;
  localparam int ND = N_CH * fircb_pkg::N_TAPS;

  logic lrst_s1_reg, link_rst_reg;
  logic frm_valid;
  logic [15:0] frm_raw;
  fircb_pkg::fircb_frame_t frm;
  logic [7:0] page_reg;
  logic [7:0] lo_pend_reg;
  logic [8:0] lo_idx_reg;
  logic lo_valid_reg;
  logic [15:0] coef_mem [NM];
  logic [15:0] dline [ND];
  logic [6:0] head_reg [N_CH];

  // Link-domain reset, synchronised from the system reset
  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= sys_rst;
    link_rst_reg <= lrst_s1_reg;
  end

  // Frames into the system domain
  fircb_cdc_word #(.W(16)) u_cdc_frame (
    .src_clk(link_clk),
    .src_rst(link_rst_reg),
    .src_valid(frame_valid),
    .src_data(frame_data),
    .src_ready(frame_ready),
    .dst_clk(clk),
    .dst_rst(sys_rst),
    .dst_valid(frm_valid),
    .dst_data(frm_raw)
  );
  assign frm = frm_raw;

  // Address decode within the selected page
  logic [7:0] pg_off_w;
  logic fir_page_w, coef_addr_w;
  logic [6:0] tap_w;
  logic [8:0] wr_idx_w;
  logic page_wr_w, lo_wr_en, hi_wr_w, commit_en, rd_req_w;
  logic [15:0] rd_word_w, commit_word_w;
  assign pg_off_w = page_reg - fircb_pkg::PAGE_FIRST;
  assign fir_page_w = (page_reg >= fircb_pkg::PAGE_FIRST) &&
                      (page_reg <= fircb_pkg::PAGE_LAST);
  assign coef_addr_w = fir_page_w &&
                       (frm.addr >= fircb_pkg::ADDR_COEF_FIRST);
  // Odd page offset holds the upper half of the bank
  assign tap_w = (pg_off_w[0] ? 7'(fircb_pkg::TAPS_PER_PAGE) : 7'd0) +
                 {1'b0, frm.addr[6:1] - fircb_pkg::WORD_COEF_FIRST};
  // Page pairs map to banks A to D
  assign wr_idx_w = {7'b0, pg_off_w[2:1]} * 9'(NT) + {2'b0, tap_w};
  assign page_wr_w = frm_valid && frm.wr &&
                     (frm.addr == fircb_pkg::ADDR_PAGE_SELECTOR);
  assign lo_wr_en = frm_valid && frm.wr && coef_addr_w && !frm.addr[0];
  assign hi_wr_w = frm_valid && frm.wr && coef_addr_w && frm.addr[0];
  // High byte commits only after its own low byte
  assign commit_en = hi_wr_w && lo_valid_reg && (lo_idx_reg == wr_idx_w);
  assign commit_word_w = {frm.data, lo_pend_reg};
  assign rd_req_w = frm_valid && !frm.wr;
  // Read answer: page_selector, coefficient word, or zero
  assign rd_word_w = (frm.addr == fircb_pkg::ADDR_PAGE_SELECTOR) ?
                     {8'h00, page_reg} :
                     (coef_addr_w ? coef_mem[wr_idx_w] : 16'h0000);

  // Page selector and pending low byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_reg <= 8'h00;
      lo_pend_reg <= 8'h00;
      lo_idx_reg <= 9'h000;
      lo_valid_reg <= 1'b0;
    end else begin
      if (page_wr_w) page_reg <= frm.data;
      if (lo_wr_en) begin
        lo_pend_reg <= frm.data;
        lo_idx_reg <= wr_idx_w;
      end
      lo_valid_reg <= lo_wr_en || (lo_valid_reg && !commit_en);
    end
  end

  // Coefficient registers, factory low-pass sets at reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NM; i++) begin
        coef_mem[i] <= fircb_pkg::dflt_coef(i);
      end
    end else if (commit_en) begin
      coef_mem[wr_idx_w] <= commit_word_w;
    end
  end

  // Read answers back to the link domain
  fircb_cdc_word #(.W(16)) u_cdc_read (
    .src_clk(clk),
    .src_rst(sys_rst),
    .src_valid(rd_req_w),
    .src_data(rd_word_w),
    .src_ready(),
    .dst_clk(link_clk),
    .dst_rst(link_rst_reg),
    .dst_valid(rd_valid),
    .dst_data(rd_data)
  );

  // Filter engine state
  fircb_pkg::fircb_state_t state_reg, state_next;
  logic [6:0] tap_k_reg, tap_k_next;
  logic signed [38:0] acc_reg, acc_next;
  logic [2:0] cur_ch_reg, cur_ch_next;
  logic [1:0] cur_bank_reg, cur_bank_next;
  logic [6:0] len_reg, len_next;
  logic sample_ready_next;
  logic accept_w, ch_ok_w;
  logic [15:0] bsel_w;
  logic [1:0] ch_bank_w;
  logic [6:0] head_next_w;
  logic [6:0] len_w;
  logic [7:0] sidx_w;
  logic signed [31:0] prod_w;
  logic signed [38:0] sh_w;
  logic [15:0] res_w;
  logic buf_in_ready, buf_in_valid;
  fircb_pkg::fircb_result_t res_pkt_w;

  // Bank field of the arriving channel
  assign bsel_w = (sample_ch < 3'(fircb_pkg::CH_PER_CFG)) ?
      (bank_select_cfg_low >> (4'd2 * {1'b0, sample_ch})) :
      (bank_select_cfg_high >> (4'd2 * {1'b0, sample_ch - 3'd3}));
  assign ch_bank_w = bsel_w[1:0];
  assign ch_ok_w = ({29'd0, sample_ch} < N_CH);
  assign accept_w = sample_valid && sample_ready;
  assign head_next_w = (head_reg[cur_ch_next] == 7'(NT - 1)) ?
                       7'd0 : head_reg[cur_ch_next] + 7'd1;

  // Active length: last nonzero tap of the bank
  always_comb begin
    len_w = 7'd0;
    for (int i = 0; i < NT; i++) begin
      if (coef_mem[int'(cur_bank_reg) * NT + i] != 16'h0000) begin
        len_w = 7'(i + 1);
      end
    end
  end

  // Tap product against the matching delayed sample
  assign sidx_w = ({1'b0, head_reg[cur_ch_reg]} >= {1'b0, tap_k_reg}) ?
      {1'b0, head_reg[cur_ch_reg]} - {1'b0, tap_k_reg} :
      {1'b0, head_reg[cur_ch_reg]} + 8'(NT) - {1'b0, tap_k_reg};
  assign prod_w =
      $signed(coef_mem[int'(cur_bank_reg) * NT + int'(tap_k_reg)]) *
      $signed(dline[int'(cur_ch_reg) * NT + int'(sidx_w)]);

  // Divide by 32768 and saturate to 16 bits
  assign sh_w = acc_reg >>> fircb_pkg::GAIN_SHIFT;
  assign res_w = (sh_w > 39'sd32767) ? 16'h7fff :
                 ((sh_w < -39'sd32768) ? 16'h8000 : sh_w[15:0]);
  assign res_pkt_w = '{ch: cur_ch_reg, delay: len_reg >> 1,
                       data: res_w};
  assign buf_in_valid = (state_reg == fircb_pkg::ST_PUSH);

  // Next-state logic of the multiply-accumulate sequence
  always_comb begin
    state_next = state_reg;
    tap_k_next = tap_k_reg;
    acc_next = acc_reg;
    cur_ch_next = cur_ch_reg;
    cur_bank_next = cur_bank_reg;
    len_next = len_reg;
    case (state_reg)
      fircb_pkg::ST_IDLE: begin
        if (accept_w) begin
          cur_ch_next = sample_ch;
          cur_bank_next = ch_bank_w;
          tap_k_next = 7'd0;
          acc_next = '0;
          state_next = ch_ok_w ? fircb_pkg::ST_MAC : fircb_pkg::ST_IDLE;
        end
      end
      fircb_pkg::ST_MAC: begin
        if (tap_k_reg < len_w) begin
          acc_next = acc_reg + {{7{prod_w[31]}}, prod_w};
          tap_k_next = tap_k_reg + 7'd1;
        end else begin
          len_next = len_w;
          state_next = fircb_pkg::ST_PUSH;
        end
      end
      fircb_pkg::ST_PUSH: begin
        if (buf_in_ready) state_next = fircb_pkg::ST_IDLE;
      end
      default: state_next = fircb_pkg::ST_IDLE;
    endcase
  end
  assign sample_ready_next = (state_next == fircb_pkg::ST_IDLE);

  // Engine registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= fircb_pkg::ST_IDLE;
      tap_k_reg <= 7'd0;
      acc_reg <= '0;
      cur_ch_reg <= 3'd0;
      cur_bank_reg <= 2'd0;
      len_reg <= 7'd0;
      sample_ready <= 1'b0;
    end else begin
      state_reg <= state_next;
      tap_k_reg <= tap_k_next;
      acc_reg <= acc_next;
      cur_ch_reg <= cur_ch_next;
      cur_bank_reg <= cur_bank_next;
      len_reg <= len_next;
      sample_ready <= sample_ready_next;
    end
  end

  // Per-channel delay lines, newest sample at the head
  // Cleared at reset so early sums see silence, not unknowns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ND; i++) begin
        dline[i] <= 16'h0000;
      end
    end else if (accept_w && ch_ok_w) begin
      dline[int'(sample_ch) * NT + int'(head_next_w)] <= sample_data;
    end
  end

  // Head pointers per channel
  generate
    for (genvar c = 0; c < N_CH; c++) begin : g_head
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          head_reg[c] <= 7'd0;
        end else if (accept_w && sample_ch == 3'(c)) begin
          head_reg[c] <= head_next_w;
        end
      end
    end
  endgenerate

  // Result buffer toward the receiver
  fircb_buf #(.W(26), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst(sys_rst),
    .in_valid(buf_in_valid),
    .in_data(res_pkt_w),
    .in_ready(buf_in_ready),
    .out_valid(filt_valid),
    .out_data(filt_data),
    .out_ready(filt_ready)
  );

  // Checks on the decode, the engine and the buffer
  sequence s_accept;
    accept_w && ch_ok_w;
  endsequence
  sequence s_mac_end;
    state_reg == fircb_pkg::ST_MAC && tap_k_reg >= len_w;
  endsequence

  a_tap71_map: assert property (@(posedge clk)
    disable iff (sys_rst)
    (page_reg == fircb_pkg::PAGE_TAP71 &&
     frm.addr == fircb_pkg::ADDR_TAP71) |-> wr_idx_w == 9'd71)
    else $error("tap 71 of bank A maps to the wrong slot");
  a_bank_d_map: assert property (@(posedge clk)
    disable iff (sys_rst)
    (page_reg == fircb_pkg::PAGE_LAST && frm.addr == 7'h08)
      |-> wr_idx_w == 9'd420)
    else $error("bank D second page maps to the wrong slot");
  a_commit_word: assert property (@(posedge clk)
    disable iff (sys_rst)
    commit_en |=> coef_mem[$past(wr_idx_w)] == $past(commit_word_w))
    else $error("coefficient word not stored on the high byte");
  a_half_hold: assert property (@(posedge clk)
    disable iff (sys_rst)
    (lo_wr_en && !commit_en) |=>
      coef_mem[$past(wr_idx_w)] == $past(coef_mem[wr_idx_w]))
    else $error("coefficient changed after a low byte alone");
  a_bank_pick: assert property (@(posedge clk) disable iff (sys_rst)
    s_accept |=> cur_bank_reg == $past(ch_bank_w) &&
                 state_reg == fircb_pkg::ST_MAC)
    else $error("sample filtered by the wrong bank");
  a_mac_length: assert property (@(posedge clk)
    disable iff (sys_rst)
    s_mac_end |-> tap_k_reg == len_w ##1
      (state_reg == fircb_pkg::ST_PUSH && len_reg == $past(len_w)))
    else $error("accumulation length differs from active taps");
  a_delay_half: assert property (@(posedge clk)
    disable iff (sys_rst)
    buf_in_valid |-> res_pkt_w.delay == (tap_k_reg >> 1))
    else $error("phase delay is not half the tap count");
  a_unity_scale: assert property (@(posedge clk)
    disable iff (sys_rst)
    (buf_in_valid && acc_reg[38:30] == 9'h000) |-> res_w == acc_reg[30:15])
    else $error("result is not the sum divided by 32768");
  a_defaults: assert property (@(posedge clk)
    $fell(sys_rst) |-> coef_mem[119] != 16'h0000 &&
      coef_mem[271] == 16'h0400 && coef_mem[272] == 16'h0000)
    else $error("factory default banks not loaded");
  a_out_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (filt_valid && !filt_ready) |=> filt_valid && $stable(filt_data))
    else $error("stalled result changed or was lost");
endmodule

// File: shared/fircb_pkg.sv
// Shared constants, carriers and defaults for the FIR coefficient banks
package fircb_pkg;
  // Geometry of the banks
  localparam int N_BANKS = 4;
  localparam int N_TAPS = 120;
  localparam int TAPS_PER_PAGE = 60;
  localparam int N_CH = 6;
  localparam int CH_PER_CFG = 3;
  localparam int BSEL_W = 2;
  localparam int COEF_W = 16;
  localparam int ACC_W = 39;
  localparam int TAP_W = 7;
  localparam int IDX_W = 9;

  // Paged memory map
  localparam logic [7:0] PAGE_FIRST = 8'h05;
  localparam logic [7:0] PAGE_LAST = 8'h0c;
  localparam logic [7:0] PAGE_TAP71 = 8'h06;
  localparam logic [6:0] ADDR_PAGE_SELECTOR = 7'h00;
  localparam logic [6:0] ADDR_COEF_FIRST = 7'h08;
  localparam logic [6:0] ADDR_TAP71 = 7'h1e;
  localparam logic [5:0] WORD_COEF_FIRST = 6'h04;

  // Gain scaling: a coefficient sum of UNITY_SUM gives gain one
  localparam int UNITY_SUM = 32768;
  localparam int GAIN_SHIFT = 15;

  // Factory default tap counts per bank
  localparam int DFLT_TAPS_A = 120;
  localparam int DFLT_TAPS_B = 120;
  localparam int DFLT_TAPS_C = 32;
  localparam int DFLT_TAPS_D = 32;

  // Serial register frame: write flag, byte address, data byte
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } fircb_frame_t;

  // Filtered result with channel and phase delay in samples
  typedef struct packed {
    logic [2:0] ch;
    logic [6:0] delay;
    logic [15:0] data;
  } fircb_result_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MAC = 3'b010,
    ST_PUSH = 3'b100
  } fircb_state_t;

  // Default low-pass: boxcar of the bank's length, remainder on tap 0
  function automatic logic [15:0] dflt_coef(input int idx);
    int bank;
    int tap;
    int n;
    bank = idx / N_TAPS;
    tap = idx % N_TAPS;
    case (bank)
      0: n = DFLT_TAPS_A;
      1: n = DFLT_TAPS_B;
      2: n = DFLT_TAPS_C;
      default: n = DFLT_TAPS_D;
    endcase
    if (tap >= n) begin
      dflt_coef = 16'h0000;
    end else if (tap == 0) begin
      dflt_coef = 16'(UNITY_SUM / n + UNITY_SUM % n);
    end else begin
      dflt_coef = 16'(UNITY_SUM / n);
    end
  endfunction
endpackage

// File: hw/fircb_cdc_word.sv
// Toggle handshake that carries one word between two clock domains
module fircb_cdc_word #(
  parameter int W = 16
) (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_ready,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);
  logic req_tgl_reg, ack_s1_reg, ack_s2_reg;
  logic req_s1_reg, req_s2_reg, ack_tgl_reg;
  logic [W-1:0] hold_reg;

  // Word is held stable until the acknowledge returns
  assign src_ready = (req_tgl_reg == ack_s2_reg);

  // Source: capture and toggle request
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req_tgl_reg <= 1'b0;
      hold_reg <= '0;
    end else if (src_valid && src_ready) begin
      req_tgl_reg <= ~req_tgl_reg;
      hold_reg <= src_data;
    end
  end

  // Source: acknowledge synchroniser
  always_ff @(posedge src_clk) begin
    ack_s1_reg <= src_rst ? 1'b0 : ack_tgl_reg;
    ack_s2_reg <= src_rst ? 1'b0 : ack_s1_reg;
  end

  // Destination: request synchroniser, pulse on change
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      ack_tgl_reg <= req_s2_reg;
      dst_valid <= (req_s2_reg != ack_tgl_reg);
      if (req_s2_reg != ack_tgl_reg) begin
        dst_data <= hold_reg;
      end
    end
  end
endmodule

// File: hw/fircb_buf.sv
// Small FIFO with valid and ready on both sides
module fircb_buf #(
  parameter int W = 26,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg, rptr_reg;
  logic [PW:0] count_reg;
  logic push, pop;

  // Honest full and empty from the count
  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

// File: testbench/fircb_host_model.sv
// Host model that sends register frames over the link
module fircb_host_model (
  // Link clock
  input wire logic link_clk,
  // Frame port
  output logic frame_valid,
  output logic [15:0] frame_data,
  input wire logic frame_ready,
  // Read answers
  input wire logic rd_valid,
  input wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link cycles before each frame, and hang count
  int gap = 0;
  int fails = 0;

  initial begin
    frame_valid = 1'b0;
    frame_data = 16'h0000;
  end

  // Offer one frame and hold it until taken
  task automatic send(input logic [15:0] f);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge link_clk);
    frame_valid <= 1'b1;
    frame_data <= f;
    do begin
      @(posedge link_clk);
      n++;
    end while (frame_ready !== 1'b1 && n < 500);
    if (n >= 500) fails++;
    frame_valid <= 1'b0;
    frame_data <= ~f; // Released bus shows no stale word
  endtask

  // Page select, low byte, then high byte
  task automatic write_word(input logic [7:0] page, input logic [6:0] addr,
                            input logic [15:0] v);
    send({1'b1, 7'h00, page});
    send({1'b1, addr, v[7:0]});
    send({1'b1, addr + 7'h01, v[15:8]});
  endtask

  // Read frame, then wait for the answer pulse
  task automatic read_word(input logic [6:0] addr, output logic [15:0] v);
    int n;
    n = 0;
    send({1'b0, addr, 8'h00});
    do begin
      @(posedge link_clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 500);
    if (n >= 500) fails++;
    v = rd_data;
  endtask
endmodule

// File: testbench/fircb_top_test.sv
// Self-checking bench for the paged FIR coefficient banks
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); \
  end \
end

module fircb_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Clocks, reset and driven inputs
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst;
  logic sample_valid;
  logic filt_ready;
  logic [2:0] sample_ch;
  logic [15:0] sample_data;
  logic [15:0] cfg_lo;
  logic [15:0] cfg_hi;
  // Design outputs and host wires
  logic frame_valid, frame_ready, rd_valid, sample_ready, filt_valid;
  logic [15:0] frame_data, rd_data, w;
  logic [25:0] filt_data, e;
  // Counters and reference state
  int err_count = 0;
  int samples_checked = 0;
  int tl [4] = '{0, 31, 32, 119};
  shortint coef [4][120];
  shortint hist [8][120];
  logic [25:0] exp_q [$];

  always #25 clk = ~clk;
  always #16 link_clk = ~link_clk;

  fircb_top uut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_ready(frame_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .bank_select_cfg_low(cfg_lo), .bank_select_cfg_high(cfg_hi),
    .sample_valid(sample_valid), .sample_ch(sample_ch),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .filt_valid(filt_valid), .filt_data(filt_data),
    .filt_ready(filt_ready));

  fircb_host_model host (.link_clk(link_clk), .frame_valid(frame_valid),
    .frame_data(frame_data), .frame_ready(frame_ready),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // Counts, verdict and end of run
  task automatic finish_test();
    err_count += host.fails;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    finish_test();
  end

  // Read one coefficient through its page and compare
  task automatic rd_chk(input int b, input int t);
    host.send(16'h8000 | 16'(5 + 2 * b + t / 60));
    host.read_word(7'(8 + 2 * (t % 60)), w);
    `CHK("coef_rd", 16'(coef[b][t]), w)
  endtask

  // Write one coefficient, read back through the odd byte
  task automatic wr_coef(input int b, input int t, input logic [15:0] v);
    host.write_word(8'(5 + 2 * b + t / 60), 7'(8 + 2 * (t % 60)), v);
    coef[b][t] = shortint'(v);
    host.read_word(7'(9 + 2 * (t % 60)), w);
    `CHK("coef_wr", v, w)
  endtask

  // Offer one sample and queue the reference result
  task automatic send_sample(input logic [2:0] ch, input logic [15:0] d);
    int n;
    int b;
    int len;
    longint acc;
    n = 0;
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_ch <= ch;
    sample_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (sample_ready !== 1'b1 && n < 400);
    if (n >= 400) err_count++;
    sample_valid <= 1'b0;
    if (ch < 3'h6) begin
      b = int'(((ch < 3'h3) ? cfg_lo : cfg_hi) >> (2 * (ch % 3))) & 3;
      for (int t = 119; t > 0; t--) hist[ch][t] = hist[ch][t - 1];
      hist[ch][0] = shortint'(d);
      acc = 0;
      len = 0;
      for (int t = 0; t < 120; t++) begin
        acc += longint'(coef[b][t]) * longint'(hist[ch][t]);
        if (coef[b][t] != 0) len = t + 1;
      end
      acc = acc >>> 15;
      if (acc > 32767) acc = 32767;
      else if (acc < -32768) acc = -32768;
      exp_q.push_back({ch, 7'(len / 2), 16'(acc)});
    end
  endtask

  // Take results in order and compare
  task automatic drain(input int k);
    int n;
    filt_ready <= 1'b1;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!(filt_valid === 1'b1 && filt_ready === 1'b1) && n < 400);
      e = exp_q.pop_front();
      `CHK("filt_data", e, filt_data)
    end
  endtask

  // Main sequence
  initial begin
    sys_rst <= 1'b1;
    sample_valid <= 1'b0;
    filt_ready <= 1'b1;
    sample_ch <= 3'h0;
    sample_data <= 16'h0000;
    cfg_lo <= 16'h0024;
    cfg_hi <= 16'h000b;
    for (int b = 0; b < 4; b++) begin
      for (int t = 0; t < 120; t++) begin
        int n;
        n = (b < 2) ? 120 : 32;
        coef[b][t] = shortint'((t < n) ?
          32768 / n + (t == 0) * (32768 % n) : 0);
      end
    end
    repeat (8) @(posedge clk);
    `CHK("ready_in_rst", 1'b0, sample_ready)
    `CHK("valid_in_rst", 1'b0, filt_valid)
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    // Factory words at both ends and at taps 31 and 32 of every bank
    for (int b = 0; b < 4; b++) begin
      foreach (tl[i]) rd_chk(b, tl[i]);
    end
    // Worked example frames for tap 71 of bank A
    host.send(16'h8006);
    host.send(16'h9e57);
    host.send(16'h9fff);
    coef[0][71] = shortint'(16'hff57);
    host.read_word(7'h1f, w);
    `CHK("tap71", 16'hff57, w)
    // Lone low byte leaves the word, newer low byte wins
    host.send(16'ha012);
    rd_chk(0, 72);
    host.send(16'ha034);
    host.send(16'ha156);
    coef[0][72] = shortint'(16'h5634);
    rd_chk(0, 72);
    // Slow host; unmapped page and unused bytes read zero
    host.gap = 5;
    host.write_word(8'h04, 7'h08, 16'hbbaa);
    host.read_word(7'h08, w);
    `CHK("unmapped", 16'h0000, w)
    host.send(16'h8005);
    host.read_word(7'h02, w);
    `CHK("unused", 16'h0000, w)
    host.read_word(7'h00, w);
    `CHK("page_selector", 16'h0005, w)
    host.gap = 0;
    // Unity gain on the 32-tap default bank
    repeat (34) begin
      send_sample(3'h2, 16'h0400);
      drain(1);
    end
    // Last tap of first page and first of second, each bank
    for (int b = 0; b < 4; b++) begin
      wr_coef(b, 59, 16'(16'h1000 + b));
      wr_coef(b, 60, 16'(16'h8000 + b));
    end
    // Every channel through its bank, then a discarded channel
    for (int i = 0; i < 12; i++) begin
      send_sample(3'(i % 6), 16'(i * 5471 - 30000));
      drain(1);
    end
    send_sample(3'h6, 16'h7fff);
    send_sample(3'h0, 16'h0100);
    drain(1);
    // Banks re-picked; upper field bits are ignored
    cfg_lo <= 16'h0039;
    cfg_hi <= 16'hffd3;
    // Receiver stalls while three results queue up
    filt_ready <= 1'b0;
    send_sample(3'h1, 16'h2000);
    send_sample(3'h3, 16'hc000);
    send_sample(3'h4, 16'h1111);
    drain(3);
    // Bank D shortened to two taps by zeroed tails
    for (int t = 2; t < 61; t++) wr_coef(3, t, 16'h0000);
    wr_coef(3, 0, 16'h7fff);
    wr_coef(3, 1, 16'h7fff);
    for (int i = 0; i < 4; i++) begin
      send_sample(3'h3, (i < 2) ? 16'h7fff : 16'h8000);
      drain(1);
    end
    finish_test();
  end
endmodule
